// file: verilog/pdct_pkg.sv
// Constants and types shared by the prescaled down-counter timer
package pdct_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PRESCALER_IDX = 8'hD2;
  localparam logic [7:0] COUNT_IDX = 8'hD3;
  localparam logic [7:0] CSR_IDX = 8'hD4;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] PRESCALER_ADDR = {2'h0, PRESCALER_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] COUNT_ADDR = {2'h0, COUNT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CSR_ADDR = {2'h0, CSR_IDX, 2'h0};

  // Control/status register field positions
  localparam int CSR_ZERO_FLAG = 7;
  localparam int CSR_ZERO_IRQ_ENABLE = 6;
  localparam int CSR_PIN_DIRECTION = 5;
  localparam int CSR_DATA_OUT = 4;
  localparam int CSR_PRESCALER_INIT = 3;
  localparam int CSR_TAP_HI = 2;
  localparam int CSR_TAP_LO = 0;

  // Widths
  localparam int COUNT_W = 8;
  localparam int PRESCALER_W = 7;
  localparam int TAP_W = 3;

  // Reset values
  localparam logic [7:0] COUNT_RESET = 8'hFF;
  localparam logic [6:0] PRESCALER_RESET = 7'h7F;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [6:0] PRESCALER_FORCED = 7'h7F;

  // Internal clock divider ratio feeding the prescaler
  localparam int INT_CLK_DIV = 12;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'(INT_CLK_DIV - 1);

  // Operating modes, coded {pin_direction_select, data_out}
  typedef enum logic [1:0] {
    PDCT_EVENT = 2'h0,
    PDCT_GATED = 2'h1,
    PDCT_OUT_LOW = 2'h2,
    PDCT_OUT_HIGH = 2'h3
  } pdct_mode_e;

endpackage : pdct_pkg

// file: verilog/pdct_sync.sv
// Two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module pdct_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Level
  input wire logic d_i,
  output logic q_o
);

  logic meta_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : pdct_sync

// file: verilog/pdct_timer.sv
// Prescaled 8-bit down-counter timer with APB register access
//
// Overview of operation
// - 8-bit counter decrements on rising edges from 7-bit down prescaler.
// - Reaching zero sets zero flag; with enable set, interrupt is raised.
// - Timer interrupt request also serves as wake-up from wait.
// - Prescaler input is internal clock divided by 12 or count pin.
// - Tap 0 uses prescaler input; tap k uses prescaler bit k-1.
// - Init bit low forces prescaler to ones and halts counting.
// - With init bit high, software may load prescaler with 0 to 7Fh.
// - Mode from direction and data-out bits: event, gated, output low/high.
// - Gated mode counts divided internal clock only while pin is high.
// - Event mode uses rising edges of count pin as prescaler clock.
// - Output mode uses divided clock; zero flag rise moves data-out to pin.
// - Output latch transparent while zero flag high, holds while low.
// - Writing 00h to count or 1 to status bit 7 sets zero flag.
// - Reset loads count and prescaler with ones, clears control register.
// - Count write beats simultaneous decrement to zero; flag stays clear.
// - Count and prescaler read exactly; count loads accepted any time.
// - Status bits 7..0: flag, enable, direction, data out, init, tap.
// - Tap codes 000 to 111 give division 1, 2, 4 ... 128.
// - Count at index D3h, prescaler at D2h with bit 7 reading zero.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pdct_timer #(
  parameter int COUNT_W = pdct_pkg::COUNT_W,
  parameter int PRESCALER_W = pdct_pkg::PRESCALER_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pdct_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Count pin, three-signal form
  input wire logic timer_pin_i,
  output logic timer_pin_o,
  output logic timer_pin_oe_b_o,
  // Interrupt and wake-up requests
  output logic zero_irq_o,
  output logic wake_o
);

  // Reset release
  logic rst_meta_q;
  logic rst_sync_b_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_b_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b_q <= rst_meta_q;
    end
  end

  // Control and status state
  logic zero_flag_q;
  logic zero_irq_enable_q;
  logic pin_direction_select_q;
  logic data_out_q;
  logic prescaler_init_q;
  logic [pdct_pkg::TAP_W-1:0] tap_select_q;
  logic [COUNT_W-1:0] count_q;
  logic [PRESCALER_W-1:0] prescaler_q;

  // APB decode
  logic setup_phase;
  logic wr_en;
  logic hit_prescaler;
  logic hit_count;
  logic hit_csr;
  logic wr_prescaler;
  logic wr_count;
  logic wr_csr;
  logic pready_q;

  assign setup_phase = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_q && pwrite_i;
  assign hit_prescaler = paddr_i == pdct_pkg::PRESCALER_ADDR;
  assign hit_count = paddr_i == pdct_pkg::COUNT_ADDR;
  assign hit_csr = paddr_i == pdct_pkg::CSR_ADDR;
  assign wr_prescaler = wr_en && hit_prescaler;
  assign wr_count = wr_en && hit_count;
  assign wr_csr = wr_en && hit_csr;

  // Ready one cycle after setup: every transfer has zero wait states
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_phase;
    end
  end

  // Read data and error, captured in the setup cycle
  logic [31:0] rdata_d;
  logic err_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (hit_prescaler) begin
      rdata_d[PRESCALER_W-1:0] = prescaler_q;
    end else if (hit_count) begin
      rdata_d[COUNT_W-1:0] = count_q;
    end else if (hit_csr) begin
      rdata_d[pdct_pkg::CSR_ZERO_FLAG] = zero_flag_q;
      rdata_d[pdct_pkg::CSR_ZERO_IRQ_ENABLE] = zero_irq_enable_q;
      rdata_d[pdct_pkg::CSR_PIN_DIRECTION] = pin_direction_select_q;
      rdata_d[pdct_pkg::CSR_DATA_OUT] = data_out_q;
      rdata_d[pdct_pkg::CSR_PRESCALER_INIT] = prescaler_init_q;
      rdata_d[pdct_pkg::CSR_TAP_HI:pdct_pkg::CSR_TAP_LO] = tap_select_q;
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_d;
    end else if (pready_q) begin
      prdata_o <= 32'h0000_0000;
    end
  end

  // Error response, standing for the access cycle only
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      pslverr_o <= err_d;
    end else if (pready_q) begin
      pslverr_o <= 1'b0;
    end
  end

  assign pready_o = pready_q;

  // Count pin synchroniser and edge detect
  logic pin_sync;
  logic pin_prev_q;
  logic pin_rise;

  pdct_sync u_pin_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_sync_b_q),
    .d_i(timer_pin_i),
    .q_o(pin_sync)
  );

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev_q;

  // Internal clock divided by 12
  logic [pdct_pkg::DIV_W-1:0] div_q;
  logic div_tick;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      div_q <= '0;
    end else if (div_q == pdct_pkg::DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign div_tick = div_q == pdct_pkg::DIV_LAST;

  // Mode decode and prescaler clock select
  pdct_pkg::pdct_mode_e mode;
  logic src_tick;

  assign mode = pdct_pkg::pdct_mode_e'({pin_direction_select_q,
                                        data_out_q});

  always_comb begin
    unique case (mode)
      pdct_pkg::PDCT_EVENT: src_tick = pin_rise;
      pdct_pkg::PDCT_GATED: src_tick = div_tick && pin_sync;
      pdct_pkg::PDCT_OUT_LOW,
      pdct_pkg::PDCT_OUT_HIGH: src_tick = div_tick;
    endcase
  end

  // Prescaler
  logic pre_tick;
  logic [PRESCALER_W-1:0] prescaler_dec;
  logic [PRESCALER_W-1:0] bit_rise;

  assign pre_tick = src_tick && prescaler_init_q;
  assign prescaler_dec = prescaler_q - 7'h01;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      prescaler_q <= pdct_pkg::PRESCALER_RESET;
    end else if (!prescaler_init_q) begin
      prescaler_q <= pdct_pkg::PRESCALER_FORCED;
    end else if (wr_prescaler) begin
      prescaler_q <= pwdata_i[PRESCALER_W-1:0];
    end else if (pre_tick) begin
      prescaler_q <= prescaler_dec;
    end
  end

  // Rising edge of each prescaler bit on a decrement
  genvar gi;
  generate
    for (gi = 0; gi < PRESCALER_W; gi++) begin : g_rise
      assign bit_rise[gi] = pre_tick && !prescaler_q[gi] &&
                            prescaler_dec[gi] && !wr_prescaler;
    end
  endgenerate

  // Counter clock: tap 0 is the prescaler input, tap k is bit k-1
  logic cnt_tick;

  always_comb begin
    if (tap_select_q == 3'h0) begin
      cnt_tick = pre_tick;
    end else begin
      cnt_tick = bit_rise[tap_select_q - 3'h1];
    end
  end

  // Counter
  logic hit_zero;

  assign hit_zero = cnt_tick && count_q == 8'h01 && !wr_count;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      count_q <= pdct_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_q <= pwdata_i[COUNT_W-1:0];
    end else if (cnt_tick) begin
      count_q <= count_q - 8'h01;
    end
  end

  // Zero flag: any set beats a software clear in the same cycle
  logic flag_set;
  logic flag_clr;

  assign flag_set = hit_zero ||
                    (wr_count && pwdata_i[COUNT_W-1:0] == 8'h00) ||
                    (wr_csr && pwdata_i[pdct_pkg::CSR_ZERO_FLAG]);
  assign flag_clr = wr_csr && !pwdata_i[pdct_pkg::CSR_ZERO_FLAG];

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      zero_flag_q <= 1'b0;
    end else if (flag_set) begin
      zero_flag_q <= 1'b1;
    end else if (flag_clr) begin
      zero_flag_q <= 1'b0;
    end
  end

  // Remaining control bits
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      zero_irq_enable_q <= pdct_pkg::CSR_RESET[6];
      pin_direction_select_q <= pdct_pkg::CSR_RESET[5];
      data_out_q <= pdct_pkg::CSR_RESET[4];
      prescaler_init_q <= pdct_pkg::CSR_RESET[3];
      tap_select_q <= pdct_pkg::CSR_RESET[2:0];
    end else if (wr_csr) begin
      zero_irq_enable_q <= pwdata_i[pdct_pkg::CSR_ZERO_IRQ_ENABLE];
      pin_direction_select_q <= pwdata_i[pdct_pkg::CSR_PIN_DIRECTION];
      data_out_q <= pwdata_i[pdct_pkg::CSR_DATA_OUT];
      prescaler_init_q <= pwdata_i[pdct_pkg::CSR_PRESCALER_INIT];
      tap_select_q <= pwdata_i[pdct_pkg::CSR_TAP_HI:pdct_pkg::CSR_TAP_LO];
    end
  end

  // Interrupt request
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      zero_irq_o <= 1'b0;
    end else begin
      zero_irq_o <= zero_flag_q && zero_irq_enable_q;
    end
  end

  // Wake-up request from wait
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= zero_flag_q && zero_irq_enable_q;
    end
  end

  // Output latch and pin drive
  logic out_latch_q;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      out_latch_q <= 1'b0;
    end else if (zero_flag_q) begin
      out_latch_q <= data_out_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      timer_pin_o <= 1'b0;
    end else begin
      timer_pin_o <= zero_flag_q ? data_out_q : out_latch_q;
    end
  end

  // Pin driven only in output mode
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      timer_pin_oe_b_o <= 1'b1;
    end else begin
      timer_pin_oe_b_o <= !pin_direction_select_q;
    end
  end

endmodule : pdct_timer

// file: testbench/pdct_timer_asserts.sv
// Port-level assertions for the prescaled down-counter timer
`timescale 1ns/1ps
module pdct_timer_asserts (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pdct_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pin and requests
  input wire logic timer_pin_oe_b_o,
  input wire logic zero_irq_o,
  input wire logic wake_o
);
  logic setup;
  logic wr_csr;
  logic mapped;
  assign setup = psel_i && !penable_i;
  assign wr_csr = psel_i && penable_i && pready_o && pwrite_i
    && paddr_i == pdct_pkg::CSR_ADDR;
  assign mapped = paddr_i inside {pdct_pkg::PRESCALER_ADDR,
    pdct_pkg::COUNT_ADDR, pdct_pkg::CSR_ADDR};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  access_ready_a: assert property (setup |=> pready_o)
    else $error("No ready in access cycle");
  ready_in_access_a: assert property (pready_o |->
    psel_i && penable_i && $past(setup)) else $error("Stray ready");
  unmapped_error_a: assert property (setup && !mapped |=> pslverr_o)
    else $error("No error for unmapped address");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr_o)
    else $error("Error on mapped address");
  psc_top_zero_a: assert property (setup && !pwrite_i &&
    paddr_i == pdct_pkg::PRESCALER_ADDR |=> prdata_o[31:7] == '0)
    else $error("Prescaler read upper bits set");
  pin_drive_a: assert property (wr_csr && pwdata_i[5]
    |-> ##[1:3] !timer_pin_oe_b_o) else $error("Pin not driven");
  pin_release_a: assert property (wr_csr && !pwdata_i[5]
    |-> ##[1:3] timer_pin_oe_b_o) else $error("Pin not released");
  irq_sw_set_a: assert property (wr_csr && pwdata_i[7:6] == 2'h3
    |-> ##[1:3] zero_irq_o) else $error("No request on flag set");
  irq_masked_a: assert property (wr_csr && !pwdata_i[6]
    |-> ##[1:3] !zero_irq_o) else $error("Request while disabled");
  wake_match_a: assert property (wake_o == zero_irq_o)
    else $error("Wake differs from request");
endmodule : pdct_timer_asserts

// file: testbench/pdct_pin_model.sv
// Outside driver of the count pin, resolving the shared wire
`timescale 1ns/1ps
module pdct_pin_model (
  // Clock
  input wire logic clk_i,
  // Pin
  input wire logic dut_o_i,
  input wire logic dut_oe_b_i,
  output logic pin_o
);
  logic drv_q = 1'b0;
  assign pin_o = dut_oe_b_i ? drv_q : dut_o_i;
  // High and low phases of w cycles each
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge clk_i);
      drv_q <= 1'b1;
      repeat (w) @(posedge clk_i);
      drv_q <= 1'b0;
      repeat (w - 1) @(posedge clk_i);
    end
  endtask : pulses
endmodule : pdct_pin_model

// file: testbench/pdct_timer_tb_top.sv
// Self-checking bench for the prescaled down-counter timer
`timescale 1ns/1ps
module pdct_timer_tb_top;
  localparam logic [11:0] P_A = pdct_pkg::PRESCALER_ADDR;
  localparam logic [11:0] C_A = pdct_pkg::COUNT_ADDR;
  localparam logic [11:0] S_A = pdct_pkg::CSR_ADDR;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pin, pin_o, pin_oe_b, irq, wake;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int checked = 0;
  integer seed = 32'h45a7;
  int n;
  always #20 clk = ~clk;
  pdct_timer i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .timer_pin_i(pin), .timer_pin_o(pin_o),
    .timer_pin_oe_b_o(pin_oe_b), .zero_irq_o(irq), .wake_o(wake));
  pdct_pin_model i_pin (.clk_i(clk), .dut_o_i(pin_o),
    .dut_oe_b_i(pin_oe_b), .pin_o(pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask : rchk
  // Count left after p input pulses on tap t, started from all ones
  function automatic logic [7:0] cnt_exp(input int p, input int t);
    return 8'(255 - (p >> t));
  endfunction : cnt_exp
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(C_A, 8'hFF);
    rchk(P_A, 8'h7F);
    rchk(S_A, 8'h00);
    apb(1'b0, 12'h354, 32'h0);
    chk(err, 1);
    n = $random(seed) & 32'h7F;
    apb(1'b1, P_A, n);
    rchk(P_A, 8'h7F);
    apb(1'b1, S_A, 32'h08);
    apb(1'b1, P_A, n);
    rchk(P_A, 8'(n));
    for (int t = 0; t < 8; t++) begin
      n = 1 + ($random(seed) & 32'hFF);
      apb(1'b1, S_A, 32'h0);
      apb(1'b1, C_A, 32'hFF);
      apb(1'b1, S_A, 32'h08 | t);
      i_pin.pulses(n, 3);
      repeat (4) @(posedge clk);
      rchk(C_A, cnt_exp(n, t));
      rchk(P_A, 8'((127 - n) & 127));
    end
    apb(1'b1, S_A, 32'h0);
    apb(1'b1, C_A, 32'h5A);
    i_pin.pulses(4, 3);
    rchk(C_A, 8'h5A);
    apb(1'b1, C_A, 32'h0);
    rchk(S_A, 8'h80);
    apb(1'b1, S_A, 32'h0);
    apb(1'b1, C_A, 32'hFF);
    apb(1'b1, S_A, 32'h18);
    n = 2 + ($random(seed) & 32'hF);
    i_pin.pulses(1, 12 * n);
    repeat (4) @(posedge clk);
    rchk(C_A, cnt_exp(n, 0));
    apb(1'b1, C_A, 32'h2);
    apb(1'b1, S_A, 32'h78);
    repeat (3) @(posedge clk);
    chk(pin, 0);
    chk(pin_oe_b, 0);
    repeat (40) @(posedge clk);
    chk(pin, 1);
    chk(irq, 1);
    chk(wake, 1);
    apb(1'b1, S_A, 32'h68);
    repeat (12) @(posedge clk);
    chk(pin, 1);
    chk(irq, 0);
    chk(wake, 0);
    apb(1'b1, S_A, 32'hE8);
    repeat (3) @(posedge clk);
    chk(pin, 0);
    apb(1'b1, S_A, 32'h0);
    finish_test();
  end
endmodule : pdct_timer_tb_top
bind pdct_timer pdct_timer_asserts i_chk (.sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .timer_pin_oe_b_o(timer_pin_oe_b_o), .zero_irq_o(zero_irq_o),
  .wake_o(wake_o));
